// file: src/csvd_map.vh
`ifndef CSVD_MAP_VH
`define CSVD_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSVD_OFS_STATE_SEL 8'h04
`define CSVD_OFS_CH1_VOL 8'h05
`define CSVD_OFS_CH2_VOL 8'h06
`define CSVD_OFS_CH3_VOL 8'h07
`define CSVD_OFS_CH4_VOL 8'h08
`define CSVD_OFS_DIAG_CTRL 8'h09
`define CSVD_OFS_THR_CH12 8'h0A
`define CSVD_OFS_THR_CH34 8'h0B
`define CSVD_OFS_RESULT_CH12 8'h0C
`define CSVD_OFS_STATE_RPT 8'h0F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSVD_RST_STATE_SEL 8'h55
`define CSVD_RST_VOL 8'hCF
`define CSVD_RST_DIAG_CTRL 8'h00
`define CSVD_RST_THR 8'h11
`define CSVD_RST_RESULT 16'h0000
`define CSVD_RST_STATE_RPT 8'h55

// ----------------------------------------------------------------
// diagnostic control bit positions
// ----------------------------------------------------------------
`define CSVD_BIT_CANCEL 7
`define CSVD_BIT_DBL_RAMP 6
`define CSVD_BIT_DBL_SETTLE 5
`define CSVD_BIT_LO_DETECT 1
`define CSVD_BIT_AUTO_SKIP 0
`define CSVD_DIAG_CTRL_MASK 8'hE3

// ----------------------------------------------------------------
// channel state codes and level codes
// ----------------------------------------------------------------
`define CSVD_ST_PLAY 2'h0
`define CSVD_ST_HIZ 2'h1
`define CSVD_ST_MUTE 2'h2
`define CSVD_ST_DIAG 2'h3
`define CSVD_GAIN_MUTE_BELOW 8'h07
`define CSVD_THR_MAX_CODE 4'h9

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSVD_CLK_MHZ 20
`define CSVD_RAMP_TIME_US 100
`define CSVD_SETTLE_TIME_US 100
// cycle counts are the times above at the clock rate, sized for the 13-bit parameters
`define CSVD_RAMP_CYCLES 13'h07D0
`define CSVD_SETTLE_CYCLES 13'h07D0

`endif

// file: src/csvd_regs.v
// Function
// [RULE1] state code 00 play, 01 high impedance, 10 mute, 11 load diagnostics
// [RULE2] state selector at 0x04, ch1 bits 7-6 down to ch4 bits 1-0, reset 0x55
// [RULE3] four 8-bit read-write volume registers at 0x05 to 0x08
// [RULE4] volume in half-dB steps, 0xCF is 0 dB, codes below 0x07 mute
// [RULE5] cancel bit 7 aborts a running diagnostic; host clears it afterwards
// [RULE6] bit 6 doubles ramp time, bit 5 doubles settle time
// [RULE7] bit 1 enables line-output detection during load diagnostics
// [RULE8] bit 0 clear runs diagnostics on leaving high impedance and after faults
// [RULE9] diagnostic control at 0x09, reset 0x00, bits 4-2 read zero
// [RULE10] threshold code n selects (n+1) times 0.5 ohm short threshold
// [RULE11] thresholds at 0x0A and 0x0B, high nibble first channel, reset 0x11
// [RULE12] first diagnostic report at 0x0C, reads 0x00 after reset
// [RULE13] report flags short-to-ground, short-to-supply, open, shorted; ch1 high nibble
// [RULE14] read-only actual state report at 0x0F, same encoding, reset 0x55
// [RULE15] threshold codes above 1001 clamp to the 5 ohm threshold
`timescale 1ns/1ps
`include "csvd_map.vh"

module csvd_regs #(
  parameter [12:0] RAMP_CYCLES = `CSVD_RAMP_CYCLES,
  parameter [12:0] SETTLE_CYCLES = `CSVD_SETTLE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire [3:0] chan_fault,
  input wire [3:0] meas_s2g,
  input wire [3:0] meas_s2p,
  input wire [3:0] meas_open,
  input wire [31:0] meas_res,
  output wire [7:0] chan_state,
  output wire [3:0] chan_mute,
  output wire [3:0] diag_ramp,
  output wire [3:0] diag_settle,
  output wire [3:0] line_out_detect_en,
  output wire [15:0] diag_flags,
  output reg [7:0] ch1_volume,
  output reg [7:0] ch2_volume,
  output reg [7:0] ch3_volume,
  output reg [7:0] ch4_volume
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg [7:0] channel_state_select;
  reg [7:0] load_diag_control;
  reg [7:0] short_threshold_ch12;
  reg [7:0] short_threshold_ch34;
  reg [15:0] diag_result;
  wire [15:0] next_result;
  wire [15:0] result_load;
  wire [31:0] gain_all;
  wire [15:0] thr_all;
  wire diag_cancel;
  wire double_ramp_time;
  wire double_settle_time;
  wire auto_diag_skip;
  wire lo_en_cfg;

  assign diag_cancel = load_diag_control[`CSVD_BIT_CANCEL];
  assign double_ramp_time = load_diag_control[`CSVD_BIT_DBL_RAMP];
  assign double_settle_time = load_diag_control[`CSVD_BIT_DBL_SETTLE];
  assign lo_en_cfg = load_diag_control[`CSVD_BIT_LO_DETECT];
  assign auto_diag_skip = load_diag_control[`CSVD_BIT_AUTO_SKIP];
  assign gain_all = {ch1_volume, ch2_volume, ch3_volume, ch4_volume};
  assign thr_all = {short_threshold_ch12, short_threshold_ch34};
  assign diag_flags = diag_result;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_state_select <= `CSVD_RST_STATE_SEL;
      ch1_volume <= `CSVD_RST_VOL;
      ch2_volume <= `CSVD_RST_VOL;
      ch3_volume <= `CSVD_RST_VOL;
      ch4_volume <= `CSVD_RST_VOL;
      load_diag_control <= `CSVD_RST_DIAG_CTRL;
      short_threshold_ch12 <= `CSVD_RST_THR;
      short_threshold_ch34 <= `CSVD_RST_THR;
    end else if (reg_wr) begin
      case (reg_addr)
        `CSVD_OFS_STATE_SEL: channel_state_select <= reg_wdata; // see [RULE2]
        `CSVD_OFS_CH1_VOL: ch1_volume <= reg_wdata; // see [RULE3]
        `CSVD_OFS_CH2_VOL: ch2_volume <= reg_wdata; // see [RULE3]
        `CSVD_OFS_CH3_VOL: ch3_volume <= reg_wdata; // see [RULE3]
        `CSVD_OFS_CH4_VOL: ch4_volume <= reg_wdata; // see [RULE3]
        // reserved bits are never stored, so they read back as zero
        `CSVD_OFS_DIAG_CTRL: load_diag_control <= reg_wdata & `CSVD_DIAG_CTRL_MASK; // see [RULE9]
        `CSVD_OFS_THR_CH12: short_threshold_ch12 <= reg_wdata; // see [RULE11]
        `CSVD_OFS_THR_CH34: short_threshold_ch34 <= reg_wdata; // see [RULE11]
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `CSVD_OFS_STATE_SEL: reg_rdata <= channel_state_select;
          `CSVD_OFS_CH1_VOL: reg_rdata <= ch1_volume;
          `CSVD_OFS_CH2_VOL: reg_rdata <= ch2_volume;
          `CSVD_OFS_CH3_VOL: reg_rdata <= ch3_volume;
          `CSVD_OFS_CH4_VOL: reg_rdata <= ch4_volume;
          `CSVD_OFS_DIAG_CTRL: reg_rdata <= load_diag_control;
          `CSVD_OFS_THR_CH12: reg_rdata <= short_threshold_ch12;
          `CSVD_OFS_THR_CH34: reg_rdata <= short_threshold_ch34;
          `CSVD_OFS_RESULT_CH12: reg_rdata <= diag_result[15:8]; // see [RULE12]
          `CSVD_OFS_STATE_RPT: reg_rdata <= chan_state; // see [RULE14]
          // unmapped offsets and the reports not built here read as zero
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostic results
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_result <= `CSVD_RST_RESULT;
    end else begin
      diag_result <= (diag_result & ~result_load) | (next_result & result_load); // see [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // per-channel sequencer
  // ----------------------------------------------------------------
  localparam [3:0] S_HIZ = 4'b0001;
  localparam [3:0] S_RAMP = 4'b0010;
  localparam [3:0] S_SETTLE = 4'b0100;
  localparam [3:0] S_ACTIVE = 4'b1000;

  // doubling is a shift, so the counters carry one bit more than the parameters
  wire [13:0] ramp_len;
  wire [13:0] settle_len;
  assign ramp_len = double_ramp_time ? {RAMP_CYCLES, 1'b0} : {1'b0, RAMP_CYCLES}; // see [RULE6]
  assign settle_len = double_settle_time ? {SETTLE_CYCLES, 1'b0} :
                      {1'b0, SETTLE_CYCLES}; // see [RULE6]

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      reg [3:0] st;
      reg [3:0] next_st;
      reg [13:0] cnt;
      reg [13:0] next_cnt;
      reg [1:0] prev_req;
      reg held;
      reg next_held;
      reg load;
      reg [1:0] rep;
      reg mute;
      reg lo_en;
      wire [1:0] req;
      wire [7:0] gain;
      wire [3:0] thr_raw;
      wire [3:0] thr_code;
      wire [7:0] thr_half_ohm;
      wire shorted;
      wire [3:0] flags;
      wire any_fault;
      wire req_changed;

      assign req = channel_state_select[2*(3-i)+1:2*(3-i)]; // see [RULE2]
      assign gain = gain_all[8*(3-i)+7:8*(3-i)];
      assign thr_raw = thr_all[4*(3-i)+3:4*(3-i)];
      assign thr_code = (thr_raw > `CSVD_THR_MAX_CODE) ? `CSVD_THR_MAX_CODE : thr_raw; // see [RULE15]
      // measured load and threshold are both in half-ohm units
      assign thr_half_ohm = {4'h0, thr_code} + 8'h01; // see [RULE10]
      assign shorted = meas_res[8*i+7:8*i] <= thr_half_ohm;
      assign flags = {meas_s2g[3-i], meas_s2p[3-i], meas_open[3-i], shorted};
      assign any_fault = |flags;
      assign req_changed = req != prev_req;
      assign next_result[4*(3-i)+3:4*(3-i)] = flags;
      assign result_load[4*(3-i)+3:4*(3-i)] = {4{load}};
      assign chan_state[2*(3-i)+1:2*(3-i)] = rep;
      assign chan_mute[3-i] = mute;
      assign diag_ramp[3-i] = st[1];
      assign diag_settle[3-i] = st[2];
      assign line_out_detect_en[3-i] = lo_en;

      always @* begin
        next_st = st;
        next_cnt = cnt;
        next_held = held;
        load = 1'b0;
        case (st)
          S_HIZ: begin
            if (req_changed) begin
              next_held = 1'b0;
            end
            // held stops a finished or aborted diagnostic from rerunning by itself
            if (req != `CSVD_ST_HIZ && (!held || req_changed) && !diag_cancel) begin
              if (req == `CSVD_ST_DIAG || !auto_diag_skip) begin // see [RULE8]
                next_st = S_RAMP;
                next_cnt = 14'h0000;
              end else begin
                next_st = S_ACTIVE;
              end
            end
          end
          S_RAMP: begin
            if (req == `CSVD_ST_HIZ || diag_cancel) begin // see [RULE5]
              next_st = S_HIZ;
              next_held = 1'b1;
            end else if (cnt >= ramp_len - 14'h0001) begin
              next_st = S_SETTLE;
              next_cnt = 14'h0000;
            end else begin
              next_cnt = cnt + 14'h0001;
            end
          end
          S_SETTLE: begin
            if (req == `CSVD_ST_HIZ || diag_cancel) begin // see [RULE5]
              next_st = S_HIZ;
              next_held = 1'b1;
            end else if (cnt >= settle_len - 14'h0001) begin
              load = 1'b1;
              // a faulty load stays off the output until the host asks again
              if (any_fault || req == `CSVD_ST_DIAG) begin
                next_st = S_HIZ;
                next_held = 1'b1;
              end else begin
                next_st = S_ACTIVE;
              end
            end else begin
              next_cnt = cnt + 14'h0001;
            end
          end
          S_ACTIVE: begin
            if (req == `CSVD_ST_HIZ) begin
              next_st = S_HIZ;
              next_held = 1'b0;
            // a set cancel bit blocks every start, so a fault then parks the channel
            end else if (req == `CSVD_ST_DIAG && !diag_cancel) begin // see [RULE5]
              next_st = S_RAMP;
              next_cnt = 14'h0000;
            end else if (chan_fault[3-i]) begin
              next_cnt = 14'h0000;
              if (!auto_diag_skip && !diag_cancel) begin // see [RULE8]
                next_st = S_RAMP;
              end else begin
                next_st = S_HIZ;
                next_held = 1'b1;
              end
            end
          end
          default: begin
            next_st = S_HIZ;
          end
        endcase
      end

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st <= S_HIZ;
          cnt <= 14'h0000;
          prev_req <= `CSVD_ST_HIZ;
          held <= 1'b0;
          rep <= `CSVD_ST_HIZ;
          mute <= 1'b1;
          lo_en <= 1'b0;
        end else begin
          st <= next_st;
          cnt <= next_cnt;
          prev_req <= req;
          held <= next_held;
          // report and mute follow the sequencer state one cycle later
          case (st)
            S_HIZ: rep <= `CSVD_ST_HIZ; // see [RULE1]
            S_RAMP: rep <= `CSVD_ST_DIAG; // see [RULE1]
            S_SETTLE: rep <= `CSVD_ST_DIAG; // see [RULE1]
            S_ACTIVE: rep <= req; // see [RULE14]
            default: rep <= `CSVD_ST_HIZ;
          endcase
          mute <= !(st == S_ACTIVE && req == `CSVD_ST_PLAY &&
                    gain >= `CSVD_GAIN_MUTE_BELOW); // see [RULE4]
          lo_en <= (st == S_RAMP || st == S_SETTLE) && lo_en_cfg; // see [RULE7]
        end
      end
    end
  endgenerate

endmodule

// file: tb/csvd_meas_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// load measurement front end
// ----------------------------------------------------------------
module csvd_meas_model (
  input wire clk,
  input wire [11:0] flag_set,
  input wire [7:0] res_set,
  input wire fault_req,
  output reg [3:0] meas_s2g = 4'h0,
  output reg [3:0] meas_s2p = 4'h0,
  output reg [3:0] meas_open = 4'h0,
  output wire [31:0] meas_res,
  output wire [3:0] chan_fault
);
  reg fault_q = 1'b0;
  // flags follow a clock late, as a sampled comparator would
  always @(posedge clk) begin
    {meas_s2g, meas_s2p, meas_open} <= flag_set;
  end
  // only ch1 gets a settable resistance, the others sit at 20 ohm
  assign meas_res = {24'h28_2828, res_set};
  always @(posedge clk) begin
    fault_q <= fault_req;
  end
  assign chan_fault = {fault_req & ~fault_q, 3'h0};
endmodule

// file: tb/csvd_regs_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register bank properties
// ----------------------------------------------------------------
module csvd_props #(
  parameter [12:0] RAMP_CYCLES = 13'h0004
) (
  input logic clk,
  input logic rst_n,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic reg_rvalid,
  input logic [7:0] chan_state,
  input logic [3:0] chan_mute,
  input logic [3:0] diag_ramp,
  input logic [3:0] diag_settle,
  input logic [3:0] line_out_detect_en,
  input logic [15:0] diag_flags,
  input logic [7:0] ch1_volume
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [13:0] ramp_run;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) ramp_run <= 14'h0000;
    else ramp_run <= diag_ramp[3] ? ramp_run + 14'h0001 : 14'h0000;
  end
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  vol_store_a: assert property (reg_wr && reg_addr == 8'h05 |=>
    ch1_volume == $past(reg_wdata)) else $error("volume write lost");
  low_vol_mute_a: assert property (ch1_volume < 8'h07 |=> chan_mute[3])
    else $error("low volume not muted");
  idle_mute_a: assert property (chan_state[7:6] != 2'h0 |-> chan_mute[3])
    else $error("silent state not muted");
  diag_state_a: assert property (diag_ramp[3] || diag_settle[3] |=>
    chan_state[7:6] == 2'h3) else $error("diagnostic state not reported");
  lo_cause_a: assert property (line_out_detect_en[3] |->
    $past(diag_ramp[3] || diag_settle[3])) else $error("line detect outside diagnostic");
  flags_cause_a: assert property ($changed(diag_flags) |->
    $past(diag_settle) != 4'h0 || $past(diag_settle, 2) != 4'h0)
    else $error("flags changed without diagnostic");
  rpt_read_a: assert property (reg_rd && reg_addr == 8'h0F |=>
    reg_rdata == $past(chan_state)) else $error("state report mismatch");
  resv_zero_a: assert property (reg_rd && reg_addr == 8'h09 |=>
    reg_rdata[4:2] == 3'h0) else $error("reserved bits not zero");
  ramp_cap_a: assert property (diag_ramp[3] |-> ramp_run < 2 * RAMP_CYCLES)
    else $error("ramp too long");
  cover property ($rose(diag_ramp[3]));
  cover property ($changed(diag_flags));
  cover property ($fell(chan_mute[3]));
endmodule

bind csvd_regs csvd_props #(.RAMP_CYCLES(RAMP_CYCLES)) u_props (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_state(chan_state),
  .chan_mute(chan_mute), .diag_ramp(diag_ramp), .diag_settle(diag_settle),
  .line_out_detect_en(line_out_detect_en), .diag_flags(diag_flags),
  .ch1_volume(ch1_volume));

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fault_req = 1'b0;
  reg lo_seen = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, res_set = 8'h03;
  reg [11:0] flag_set = 12'h008;
  reg [7:0] ra [0:10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
    8'h0F, 8'h00};
  reg [7:0] re [0:10] = '{8'h55, 8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'h00, 8'h11, 8'h11, 8'h00,
    8'h55, 8'h00};
  wire [7:0] reg_rdata, chan_state, v1, v2, v3, v4;
  wire [3:0] s2g, s2p, opn, fault, chan_mute, diag_ramp, diag_settle, lo_en;
  wire [31:0] res;
  wire [15:0] diag_flags;
  wire reg_rvalid;
  integer mismatches = 0, checks = 0, cyc = 0, i, n;
  csvd_regs #(.RAMP_CYCLES(13'h0004), .SETTLE_CYCLES(13'h0004)) dut (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_fault(fault),
    .meas_s2g(s2g), .meas_s2p(s2p), .meas_open(opn), .meas_res(res),
    .chan_state(chan_state), .chan_mute(chan_mute), .diag_ramp(diag_ramp),
    .diag_settle(diag_settle), .line_out_detect_en(lo_en), .diag_flags(diag_flags),
    .ch1_volume(v1), .ch2_volume(v2), .ch3_volume(v3), .ch4_volume(v4));
  csvd_meas_model model (.clk(clk), .flag_set(flag_set), .res_set(res_set),
    .fault_req(fault_req), .meas_s2g(s2g), .meas_s2p(s2p), .meas_open(opn),
    .meas_res(res), .chan_fault(fault));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (lo_en[3]) lo_seen <= 1'b1;
    cyc <= cyc + 1;
    // the whole run needs about 180 cycles
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({reg_rvalid, reg_rdata}, {1'b1, e}, "read");
  endtask
  // restart ch1 from high impedance and time its ramp
  task run_ch1(input [7:0] ctrl);
    wr(8'h09, ctrl);
    wr(8'h04, 8'h55);
    wr(8'h04, 8'h15);
    n = 0;
    for (i = 0; i < 20 && diag_ramp[3] !== 1'b1; i = i + 1) @(negedge clk);
    while (diag_ramp[3] === 1'b1 && n < 40) begin
      n = n + 1;
      @(negedge clk);
    end
    repeat (12) @(negedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 11; i = i + 1) rd(ra[i], re[i]);
    wr(8'h05, 8'h10);
    wr(8'h06, 8'h06);
    wr(8'h07, 8'hFF);
    wr(8'h08, 8'h07);
    wr(8'h0C, 8'hAA);
    wr(8'h0F, 8'h00);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hE3);
    rd(8'h05, 8'h10);
    rd(8'h06, 8'h06);
    rd(8'h07, 8'hFF);
    rd(8'h08, 8'h07);
    chk({v2, v3}, 16'h06FF, "vol23");
    chk({v1, v4}, 16'h1007, "vol14");
    rd(8'h0C, 8'h00);
    rd(8'h0F, 8'h55);
    chk(chan_mute, 4'hF, "mute");
    // open load keeps ch1 in high impedance
    run_ch1(8'h00);
    chk(n, 4, "ramp");
    chk(chan_state, 8'h55, "state");
    rd(8'h0C, 8'h20);
    chk(lo_seen, 1'b0, "lo_off");
    // a reserved code clamps to the 5 ohm threshold
    flag_set = 12'h000;
    res_set = 8'h0A;
    wr(8'h0A, 8'hF1);
    run_ch1(8'h42);
    chk(n, 8, "ramp2x");
    rd(8'h0C, 8'h10);
    chk(lo_seen, 1'b1, "lo_on");
    res_set = 8'h0B;
    run_ch1(8'h00);
    chk(chan_state, 8'h15, "play");
    chk(chan_mute[3], 1'b0, "unmute");
    rd(8'h0C, 8'h00);
    wr(8'h05, 8'h06);
    repeat (3) @(negedge clk);
    chk(chan_mute[3], 1'b1, "lowvol");
    wr(8'h09, 8'h01);
    fault_req = 1'b1;
    @(negedge clk);
    fault_req = 1'b0;
    repeat (4) @(negedge clk);
    chk(chan_state[7:6], 2'h1, "fault");
    chk(diag_ramp[3], 1'b0, "noauto");
    wr(8'h04, 8'h25);
    repeat (4) @(negedge clk);
    chk(chan_state[5:4], 2'h2, "bypass");
    wr(8'h09, 8'h00);
    // an open load on ch3 would reach its flags if the abort failed
    flag_set = 12'h002;
    wr(8'h04, 8'h2D);
    wr(8'h09, 8'h80);
    @(negedge clk);
    chk({diag_ramp[1], diag_settle[1]}, 2'h0, "abortnow");
    repeat (12) @(negedge clk);
    chk(chan_state[3:2], 2'h1, "abort");
    chk(diag_flags[7:4], 4'h0, "abortfl");
    wr(8'h09, 8'h00);
    end_of_test;
  end
endmodule
